// *** logic/diag_fault_filter.sv ***
`timescale 1ns/10ps

// keeps a fault only if it stayed present over the whole window
module diag_fault_filter
   import speaker_diag_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // window control
   input wire logic windowOpen,
   input wire logic windowSample,
   // raw and qualified faults
   input wire chan_fault_t rawFault,
   output chan_fault_t stableFault
);

   // a single dropout during the window clears the bit for this cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stableFault <= '0;
      end else if (windowOpen) begin
         stableFault <= rawFault;
      end else if (windowSample) begin
         stableFault <= stableFault & rawFault;
      end
   end

endmodule

// *** logic/speaker_diag_consts.svh ***
`ifndef SPEAKER_DIAG_CONSTS_SVH
`define SPEAKER_DIAG_CONSTS_SVH

// clock rate and measurement window
`define CLK_SYS_MHZ 250
`define DIAG_MEAS_TIME_NS 1000
`define DIAG_MEAS_CYCLES ((`DIAG_MEAS_TIME_NS * `CLK_SYS_MHZ) / 1000)
`define DIAG_CNT_W 10

// status byte count and index width
`define DIAG_BYTE_COUNT 4
`define DIAG_IDX_W 3

// common channel field positions (all four bytes)
`define FLD_PERMANENT 4
`define FLD_SHORT_LOAD 3
`define FLD_OPEN_OFFSET 2
`define FLD_SHORT_VCC 1
`define FLD_SHORT_GND 0

// spare bits of individual bytes
`define FLD_THERMAL_WARN 7
`define FLD_CYCLE_DONE 6
`define FLD_OFFSET_ACTIVE 7
`define FLD_STANDBY_ECHO 7
`define FLD_DIAG_EN_ECHO 6

// reset value of every status byte and of the read data
`define DIAG_BYTE_RESET 8'h00

`endif

// *** logic/speaker_diag_pkg.sv ***
package speaker_diag_pkg;

   // raw fault levels of one channel, as seen by the analog comparators
   typedef struct packed {
      logic shortLoad;
      logic openLoad;
      logic offset;
      logic shortVcc;
      logic shortGnd;
   } chan_fault_t;

   // qualified result of one channel for one diagnostic cycle
   typedef struct packed {
      logic permanent;
      logic shortLoad;
      logic openOrOffset;
      logic shortVcc;
      logic shortGnd;
   } chan_result_t;

   // read transfer events from the serial protocol engine
   typedef struct packed {
      logic start;
      logic next;
      logic stop;
   } read_ctl_t;

   // settings last written by the host
   typedef struct packed {
      logic diagEnable;
      logic offsetEnable;
      logic standbyOff;
   } host_cfg_t;

   typedef enum logic [1:0] {
      CYC_IDLE,
      CYC_MEASURE,
      CYC_DONE
   } cycle_state_t;

endpackage

// *** logic/speaker_diag_status_bytes.sv ***
`timescale 1ns/10ps
`include "speaker_diag_consts.svh"

module speaker_diag_status_bytes
   import speaker_diag_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // host settings from the instruction bytes
   input wire host_cfg_t hostCfg,
   // analog condition inputs, index 0..3 = left front, left rear, right front, right rear
   input wire logic thermalWarn,
   input wire chan_fault_t rawFault [`DIAG_BYTE_COUNT],
   // read transfer events from the protocol engine
   input wire read_ctl_t readCtl,
   // byte to shift out and cycle status
   output logic [7:0] readData,
   output logic readDataValid,
   output logic cycleDone
);

   cycle_state_t cycleState;
   logic [`DIAG_CNT_W-1:0] measCount;
   logic permanentPhase;
   logic offsetPhase;
   logic windowOpen;
   logic windowSample;
   logic readActive;
   logic [`DIAG_IDX_W-1:0] byteIndex;
   chan_fault_t stableFault [`DIAG_BYTE_COUNT];
   chan_result_t chanResult [`DIAG_BYTE_COUNT];
   logic [7:0] snapshot [`DIAG_BYTE_COUNT];
   logic [7:0] next_byte [`DIAG_BYTE_COUNT];

   // packs the channel field layout shared by all four bytes
   function automatic logic [7:0] chan_byte(input chan_result_t r);
      logic [7:0] b;
      b = `DIAG_BYTE_RESET; // undefined bits read zero
      b[`FLD_PERMANENT] = r.permanent;
      b[`FLD_SHORT_LOAD] = r.shortLoad;
      b[`FLD_OPEN_OFFSET] = r.openOrOffset;
      b[`FLD_SHORT_VCC] = r.shortVcc;
      b[`FLD_SHORT_GND] = r.shortGnd;
      return b;
   endfunction

   // a read counts as complete once the stop follows a started read
   logic readComplete;
   logic cycleEnd;
   assign readComplete = readCtl.stop & readActive;

   // all inputs passed in, so the continuous assignment below sees every change
   function automatic logic next_state_measure(input cycle_state_t st, input host_cfg_t cfg,
                                               input logic rdDone);
      logic go;
      go = 1'b0;
      case (st)
         CYC_IDLE: begin
            go = cfg.diagEnable | cfg.offsetEnable;
         end
         CYC_DONE: begin
            go = rdDone & (cfg.diagEnable | cfg.offsetEnable);
         end
         default: begin
            go = 1'b0;
         end
      endcase
      return go;
   endfunction

   // the window opens on the first cycle of a measurement
   assign windowOpen = (cycleState != CYC_MEASURE) && next_state_measure(cycleState, hostCfg, readComplete);
   assign windowSample = (cycleState == CYC_MEASURE);
   // last count of a live window; a defeat on that very edge discards the results
   assign cycleEnd = (cycleState == CYC_MEASURE) && (hostCfg.diagEnable || hostCfg.offsetEnable)
                     && (measCount == `DIAG_CNT_W'(`DIAG_MEAS_CYCLES - 1));

   // one qualifier per channel
   for (genvar ch = 0; ch < `DIAG_BYTE_COUNT; ch++) begin : gFilt
      diag_fault_filter uFilter (
         .clk_sys(clk_sys),
         .rst(rst),
         .windowOpen(windowOpen),
         .windowSample(windowSample),
         .rawFault(rawFault[ch]),
         .stableFault(stableFault[ch])
      );
   end

   // diagnostic cycle sequencer: measure, hold results until a read, then rerun if either diagnostic is still enabled
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cycleState <= CYC_IDLE;
         measCount <= '0;
      end else begin
         case (cycleState)
            CYC_IDLE: begin
               if (windowOpen) begin
                  cycleState <= CYC_MEASURE;
                  measCount <= '0;
               end
            end
            CYC_MEASURE: begin
               if (!hostCfg.diagEnable && !hostCfg.offsetEnable) begin
                  cycleState <= CYC_IDLE; // defeat aborts an unfinished cycle
               end else if (measCount == `DIAG_CNT_W'(`DIAG_MEAS_CYCLES - 1)) begin
                  cycleState <= CYC_DONE;
               end else begin
                  measCount <= measCount + `DIAG_CNT_W'(1);
               end
            end
            CYC_DONE: begin
               if (readComplete) begin
                  // restart keeps the diagnostics resident
                  cycleState <= windowOpen ? CYC_MEASURE : CYC_IDLE;
                  measCount <= '0;
               end
            end
            default: begin
               cycleState <= CYC_IDLE;
            end
         endcase
      end
   end

   // first finished cycle after enable is turn-on, later ones are permanent
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         permanentPhase <= 1'b0;
      end else if (!hostCfg.diagEnable) begin
         permanentPhase <= 1'b0;
      end else if (cycleEnd) begin
         permanentPhase <= 1'b1;
      end
   end

   // offset mode is fixed for the whole cycle when the window opens
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         offsetPhase <= 1'b0;
      end else if (windowOpen) begin
         offsetPhase <= hostCfg.offsetEnable;
      end
   end

   // results land only at the end of a full window
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int ch = 0; ch < `DIAG_BYTE_COUNT; ch++) begin
            chanResult[ch] <= '0;
         end
      end else if (cycleEnd) begin
         for (int ch = 0; ch < `DIAG_BYTE_COUNT; ch++) begin
            chanResult[ch].permanent <= permanentPhase;
            chanResult[ch].shortLoad <= stableFault[ch].shortLoad & rawFault[ch].shortLoad;
            chanResult[ch].shortVcc <= stableFault[ch].shortVcc & rawFault[ch].shortVcc;
            chanResult[ch].shortGnd <= stableFault[ch].shortGnd & rawFault[ch].shortGnd;
            if (offsetPhase) begin
               chanResult[ch].openOrOffset <= stableFault[ch].offset & rawFault[ch].offset;
            end else if (!permanentPhase) begin
               chanResult[ch].openOrOffset <= stableFault[ch].openLoad & rawFault[ch].openLoad;
            end else begin
               chanResult[ch].openOrOffset <= 1'b0; // open load is not seen while playing
            end
         end
      end
   end

   // cycle-done flag holds until a read completes, then drops whether or not a new cycle starts
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cycleDone <= 1'b0;
      end else begin
         cycleDone <= cycleEnd || (cycleState == CYC_DONE && !readComplete);
      end
   end

   // byte images, in left front, left rear, right front, right rear order
   always_comb begin
      for (int ch = 0; ch < `DIAG_BYTE_COUNT; ch++) begin
         next_byte[ch] = chan_byte(chanResult[ch]);
      end
      next_byte[0][`FLD_THERMAL_WARN] = thermalWarn;
      next_byte[0][`FLD_CYCLE_DONE] = cycleDone;
      next_byte[1][`FLD_OFFSET_ACTIVE] = hostCfg.offsetEnable;
      next_byte[2][`FLD_STANDBY_ECHO] = hostCfg.standbyOff;
      next_byte[2][`FLD_DIAG_EN_ECHO] = hostCfg.diagEnable;
   end

   // all four bytes frozen together so one read is self-consistent
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int ch = 0; ch < `DIAG_BYTE_COUNT; ch++) begin
            snapshot[ch] <= `DIAG_BYTE_RESET;
         end
      end else if (readCtl.start) begin
         for (int ch = 0; ch < `DIAG_BYTE_COUNT; ch++) begin
            snapshot[ch] <= next_byte[ch];
         end
      end
   end

   // read pointer: start loads byte one, each acked byte advances
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         readActive <= 1'b0;
         byteIndex <= '0;
      end else if (readCtl.start) begin
         readActive <= 1'b1;
         byteIndex <= '0;
      end else if (readCtl.stop) begin
         readActive <= 1'b0;
      end else if (readActive && readCtl.next && byteIndex != `DIAG_IDX_W'(`DIAG_BYTE_COUNT)) begin
         byteIndex <= byteIndex + `DIAG_IDX_W'(1);
      end
   end

   // shift-out byte; beyond the fourth byte the bus sees zeros
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         readData <= `DIAG_BYTE_RESET;
         readDataValid <= 1'b0;
      end else if (readCtl.start) begin
         readData <= next_byte[0];
         readDataValid <= 1'b1;
      end else if (readCtl.stop) begin
         readData <= `DIAG_BYTE_RESET;
         readDataValid <= 1'b0;
      end else if (readActive && readCtl.next) begin
         if (byteIndex < `DIAG_IDX_W'(`DIAG_BYTE_COUNT - 1)) begin
            readData <= snapshot[byteIndex[1:0] + 2'd1];
            readDataValid <= 1'b1;
         end else begin
            readData <= `DIAG_BYTE_RESET;
            readDataValid <= 1'b0;
         end
      end
   end

endmodule

// *** verification/diag_host_reader.sv ***
`timescale 1ns/10ps
// serial engine serving a host read; gap sets how slowly the host acks
module diag_host_reader
   import speaker_diag_pkg::*;
(
   // clock and command
   input wire logic clk_sys,
   input wire logic go,
   input wire logic [3:0] gap,
   // events and returned bytes
   input wire logic [7:0] readData,
   output read_ctl_t readCtl,
   output logic [7:0] got [4],
   output logic busy
);
   // start, three acks, stop; gap of at least 1 lets each byte land first
   initial begin
      readCtl = '0;
      busy = 1'h0;
      forever begin
         @(posedge clk_sys);
         if (go) begin
            busy <= 1'h1;
            readCtl.start <= 1'h1;
            @(posedge clk_sys) readCtl <= '0;
            for (int i = 0; i < 4; i++) begin
               repeat (gap) @(posedge clk_sys);
               got[i] = readData;
               readCtl.next <= (i < 3);
               readCtl.stop <= (i == 3);
               @(posedge clk_sys) readCtl <= '0;
            end
            busy <= 1'h0;
         end
      end
   end
endmodule

// *** verification/speaker_diag_status_bytes_bench.sv ***
`timescale 1ns/10ps
`include "speaker_diag_consts.svh"
// directed checks of the diagnostic status bytes
module speaker_diag_status_bytes_bench import speaker_diag_pkg::*;;
   logic clk_sys = 1'h0;
   logic rst = 1'h1;
   host_cfg_t hostCfg = '0;
   logic thermalWarn = 1'h0;
   chan_fault_t rawFault [`DIAG_BYTE_COUNT] = '{default: '0};
   read_ctl_t readCtl;
   logic [7:0] readData;
   logic [7:0] got [4];
   logic readDataValid, cycleDone, busy;
   logic go = 1'h0;
   logic [3:0] gap = 4'h1;
   int mismatches = 0;
   int checked = 0;

   // design and host-side reader
   speaker_diag_status_bytes speaker_diag_status_bytes_i (.clk_sys(clk_sys), .rst(rst), .hostCfg(hostCfg),
      .thermalWarn(thermalWarn), .rawFault(rawFault), .readCtl(readCtl), .readData(readData),
      .readDataValid(readDataValid), .cycleDone(cycleDone));
   diag_host_reader diag_host_reader_i (.clk_sys(clk_sys), .go(go), .gap(gap), .readData(readData),
      .readCtl(readCtl), .got(got), .busy(busy));

   initial forever #2 clk_sys = ~clk_sys;

   task automatic chk8(input logic [7:0] act, input logic [7:0] exp);
      checked++;
      if (act !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, act, exp);
      end
   endtask

   // one whole read through the reader, bytes compared in order
   task automatic rd(input logic [7:0] e [4]);
      int n;
      n = 0;
      @(posedge clk_sys) go <= 1'h1;
      @(posedge clk_sys) go <= 1'h0;
      do @(posedge clk_sys); while (busy && ++n < 200);
      chk8({7'h0, busy}, 8'h00);
      for (int i = 0; i < 4; i++) chk8(got[i], e[i]);
   endtask

   // bounded wait; a cycle is 250 counts long
   task automatic waitDone;
      int n;
      n = 0;
      while (cycleDone !== 1'h1 && n < 400) begin
         @(posedge clk_sys);
         n++;
      end
      chk8({7'h0, cycleDone}, 8'h01);
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // idle state, then a read while the first cycle still measures
   task automatic test_early;
      @(posedge clk_sys);
      chk8(readData, 8'h00);
      chk8({7'h0, readDataValid, cycleDone}, 8'h00);
      hostCfg.diagEnable <= 1'h1;
      hostCfg.standbyOff <= 1'h1;
      thermalWarn <= 1'h1;
      rawFault <= '{5'h14, 5'h08, 5'h02, 5'h01};
      rd('{8'h80, 8'h00, 8'hc0, 8'h00});
      $display("test_early done");
   endtask

   // turn-on results with a slow host; offset disabled so ch0 offset stays hidden
   task automatic test_turnon;
      waitDone();
      @(posedge clk_sys) gap <= 4'h3;
      rd('{8'hc8, 8'h04, 8'hc2, 8'h01});
      gap <= 4'h1;
      $display("test_turnon done");
   endtask

   // faults gone mid-window: first read stale, second shows permanent and clean
   task automatic test_permanent;
      rawFault <= '{default: '0};
      rd('{8'h88, 8'h04, 8'hc2, 8'h01});
      waitDone();
      rd('{8'hd0, 8'h10, 8'hd0, 8'h10});
      $display("test_permanent done");
   endtask

   // offset mode only applies from the next window; ch3 drops out briefly inside that window
   task automatic test_offset;
      @(posedge clk_sys);
      hostCfg.offsetEnable <= 1'h1;
      thermalWarn <= 1'h0;
      rawFault[1] <= 5'h04;
      rawFault[3] <= 5'h01;
      rd('{8'h10, 8'h90, 8'hd0, 8'h10});
      waitDone();
      rd('{8'h50, 8'h90, 8'hd0, 8'h10});
      repeat (100) @(posedge clk_sys);
      rawFault[3] <= 5'h00;
      repeat (5) @(posedge clk_sys);
      rawFault[3] <= 5'h01;
      waitDone();
      rd('{8'h50, 8'h94, 8'hd0, 8'h10});
      $display("test_offset done");
   endtask

   // both diagnostics defeated mid-window: no new results, echo bits follow the settings
   task automatic test_abort;
      @(posedge clk_sys);
      hostCfg.diagEnable <= 1'h0;
      hostCfg.offsetEnable <= 1'h0;
      repeat (300) @(posedge clk_sys);
      chk8({7'h0, cycleDone}, 8'h00);
      rd('{8'h10, 8'h14, 8'h90, 8'h10});
      $display("test_abort done");
   endtask

   // reset, then the scenarios in order
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'h0;
      test_early();
      test_turnon();
      test_permanent();
      test_offset();
      test_abort();
      wrap_up();
   end

   // the run needs about 1400 cycles
   initial begin
      repeat (6000) @(posedge clk_sys);
      mismatches++;
      $display("ERROR %0t watchdog expired", $time);
      wrap_up();
   end
endmodule

// *** verification/speaker_diag_status_bytes_monitor.sv ***
`timescale 1ns/10ps
`include "speaker_diag_consts.svh"
// watches read port and cycle flag of the status bank
module speaker_diag_status_bytes_monitor
   import speaker_diag_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // inputs
   input wire host_cfg_t hostCfg,
   input wire logic thermalWarn,
   input wire chan_fault_t rawFault [`DIAG_BYTE_COUNT],
   input wire read_ctl_t readCtl,
   // outputs
   input wire logic [7:0] readData,
   input wire logic readDataValid,
   input wire logic cycleDone
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // snapshot is taken at start, so $past picks the live value seen then
   a_start_valid: assert property (readCtl.start |=> readDataValid)
      else $error("no byte after start");
   a_byte0_thermal: assert property (readCtl.start |=> readData[7] == $past(thermalWarn))
      else $error("thermal bit wrong");
   a_byte0_done: assert property (readCtl.start |=> readData[6] == $past(cycleDone))
      else $error("done bit wrong");
   a_spare_zero: assert property (readDataValid |-> !readData[5])
      else $error("bit 5 set");
   a_byte1_offset: assert property (readCtl.start ##2 readCtl.next |=>
      readData[7] == $past(hostCfg.offsetEnable, 3)) else $error("offset active bit wrong");
   a_stop_clear: assert property (readCtl.stop |=> !readDataValid && readData == 8'h00)
      else $error("read not closed");
   a_idle_zero: assert property (!readDataValid |-> readData == 8'h00)
      else $error("data outside read");
   a_done_hold: assert property (cycleDone && !readCtl.stop |=> cycleDone)
      else $error("done dropped");
   a_done_restart: assert property (readCtl.stop && cycleDone &&
      (hostCfg.diagEnable || hostCfg.offsetEnable) |-> ##2 !cycleDone [*8]) else $error("no restart");
   // main scenarios
   cover property (readCtl.start);
   cover property ($rose(cycleDone));
   cover property (readCtl.stop && cycleDone);
endmodule

bind speaker_diag_status_bytes speaker_diag_status_bytes_monitor speaker_diag_status_bytes_monitor_i (
   .clk_sys(clk_sys), .rst(rst), .hostCfg(hostCfg), .thermalWarn(thermalWarn), .rawFault(rawFault),
   .readCtl(readCtl), .readData(readData), .readDataValid(readDataValid), .cycleDone(cycleDone));
